/* logic/sbc_pkg.sv */
package sbc_pkg;
	localparam int          SBC_RES_N   = 8;
	localparam int          SBC_DSP_N   = 8;
	localparam int          SBC_NS_N    = 4;
	localparam int          SBC_VS_N    = 4;
	localparam int          SBC_AW      = 32;
	localparam int          SBC_MD_W    = 256;
	localparam int          SBC_NS_W    = 128;
	localparam int          SBC_VS_W    = 256;
	localparam int          SBC_RE_W    = 64;
	localparam int          SBC_SCW_W   = 100;
	localparam int          SBC_VREF    = 127;
	localparam int          SBC_PST_N   = 3;
	localparam logic [7:0]  SBC_SEG_MIN = 8'h04;
	localparam logic [2:0]  SBC_NS_FULL = 3'h4;
	localparam int          SBC_HWS_LSB = 0;
	localparam int          SBC_HWS_W   = 16;
	localparam int          SBC_CHL_LSB = 16;
	localparam int          SBC_CHL_W   = 16;

	typedef enum logic [3:0] {
		C_NOP, C_PCALL, C_RES_RD, C_DISP_RD, C_NS_PUSH, C_NS_POP, C_SLICE, C_EXEC, C_UNSLICE, C_PRET
	} sbc_cmd_t;

	typedef enum logic [10:0] {
		ST_IDLE  = 11'h001,
		ST_MEM   = 11'h002,
		ST_PUSH  = 11'h004,
		ST_POP   = 11'h008,
		ST_SLICE = 11'h010,
		ST_EXEC  = 11'h020,
		ST_UPD   = 11'h040,
		ST_UPDN  = 11'h080,
		ST_UNSL  = 11'h100,
		ST_DRD   = 11'h200,
		ST_HOLD  = 11'h400
	} sbc_fsm_t;

	typedef enum logic [2:0] {M_RES, M_PCALL, M_NSPL, M_VSPL, M_NFIL, M_VFIL, M_DSP, M_SCW} sbc_mop_t;

	typedef struct packed {
		logic [63:0] disp;
		logic [7:0]  lex;
		logic [27:0] len;
	} sbc_scw_t;

	typedef struct packed {
		logic                req;
		logic                we;
		logic [SBC_AW-1:0]   addr;
		logic [SBC_MD_W-1:0] wdata;
	} sbc_mreq_t;

	typedef struct packed {
		sbc_cmd_t            op;
		logic [7:0]          seg;
		logic [7:0]          lvl;
		logic [SBC_NS_W-1:0] nsd;
		logic [SBC_VS_W-1:0] vsd;
		logic [63:0]         desc;
		logic [27:0]         len;
		logic [SBC_AW-1:0]   link;
	} sbc_req_t;

	function automatic logic [3:0] sbc_hit(logic [7:0][7:0] tg, logic [7:0] v, logic [7:0] k);
		logic [3:0] r;
		r = 4'h0;
		for (int i = 7; i >= 0; i--) begin
			if (v[i] && tg[i] == k)
				r = {1'b1, 3'(i)};
		end
		return r;
	endfunction : sbc_hit

	function automatic logic [3:0] sbc_free(logic [7:0] v);
		logic [3:0] r;
		r = 4'h0;
		for (int i = 7; i >= 0; i--) begin
			if (!v[i])
				r = {1'b1, 3'(i)};
		end
		return r;
	endfunction : sbc_free
endpackage : sbc_pkg

/* logic/sbc_top.sv */
`timescale 1ns/10ps
// Functional notes
// - process call loads environment entry into slot zero, sets hw state and halt
// - next three slice entries go to the interrupt section registers
// - eight 64-bit resource slots, each with a segment-number tag
// - process call marks every resource slot empty, environment included, then reloads slot zero
// - every access from segment 4 up compares segment with tags; a hit is served locally
// - a miss fetches from level-1 into first empty slot and sets its tag
// - when full, the oldest non-environment slot is overwritten
// - segment numbers 0 to 3 fault and skip the lookup
// - segment number indexes the resource entry within the current slice
// - top four name stack entries held locally, 128 bits, occupancy varies
// - expression entries reachable only by push and pop
// - display accesses check tags; misses fetched, replacing oldest of eight
// - slice and call add display entries; unslice and return remove them
// - control word holds 28-bit length, 8-bit level, 64-bit display field
// - slice saves top display entry in the word and enters new description
// - execute fetches declaring control word by lexic link, level plus one
// - update compares saved field with entry at level minus one, walks on
// - unslice removes without update; return removes then updates display
// - name stack top is checked for a value reference before arithmetic
// - value stack slices follow name stack slices
// - four 256-bit value buffers spill and fill to level-1
// - name stack changes on value references also change the value stack
module sbc_top
	import sbc_pkg::*;
(
	input  wire logic                          ref_clk_i,   // clock
	input  wire logic                          reset_n_i,   // async reset
	input  wire sbc_pkg::sbc_req_t             req_i,       // kernel request
	output logic                               rdy_o,       // ready for a request
	output logic                               fault_o,     // segment or empty-pop fault pulse
	output logic                               rvld_o,      // resource data pulse
	output logic                               dvld_o,      // display data pulse
	output logic [sbc_pkg::SBC_RE_W-1:0]       rdat_o,      // resource/display data
	output logic                               pvld_o,      // pop pulse
	output logic [sbc_pkg::SBC_NS_W-1:0]       pop_o,       // popped name entry
	output logic                               vref_o,      // name top is value ref
	output logic [sbc_pkg::SBC_VS_W-1:0]       vtop_o,      // value stack top
	output logic [7:0]                         lex_o,       // current lexic level
	output logic [7:0]                         vsl_o,       // value stack slices
	output logic [sbc_pkg::SBC_HWS_W-1:0]      hws_o,       // hardware state
	output logic [sbc_pkg::SBC_CHL_W-1:0]      chalt_o,     // conditional halt
	output logic [2:0][sbc_pkg::SBC_RE_W-1:0]  pst_o,       // processor state words
	output logic                               pld_o,       // state words loaded pulse
	input  wire logic [sbc_pkg::SBC_AW-1:0]    rs_base_i,   // resource slice base
	input  wire logic [sbc_pkg::SBC_AW-1:0]    ds_base_i,   // display base
	input  wire logic [sbc_pkg::SBC_AW-1:0]    ns_base_i,   // name stack base
	input  wire logic [sbc_pkg::SBC_AW-1:0]    vs_base_i,   // value stack spill base
	output sbc_pkg::sbc_mreq_t                 mem_o,       // level-1 request
	input  wire logic                          mem_ack_i,   // level-1 done
	input  wire logic [sbc_pkg::SBC_MD_W-1:0]  mem_rdata_i  // level-1 read data
);
	import sbc_pkg::*;

	typedef struct packed {
		sbc_fsm_t                   st;
		sbc_fsm_t                   ret;
		sbc_fsm_t                   nxt;
		sbc_mop_t                   mop;
		logic                       rdy;
		logic                       flt;
		logic                       rv;
		logic                       dvl;
		logic                       pv;
		logic                       pld;
		logic                       vref;
		logic [1:0]                 idx;
		sbc_req_t                   rq;
		logic [7:0][63:0]           rdat_a;
		logic [7:0][7:0]            rtag;
		logic [7:0]                 rval;
		logic [2:0]                 rp;
		logic [7:0][63:0]           ddat;
		logic [7:0][7:0]            dtag;
		logic [7:0]                 dval;
		logic [2:0]                 dp;
		logic [7:0]                 key;
		logic [3:0][SBC_NS_W-1:0]   ns;
		logic [2:0]                 nsc;
		logic [SBC_AW-1:0]          nsp;
		logic [3:0][SBC_VS_W-1:0]   vs;
		logic [2:0]                 vsc;
		logic [SBC_AW-1:0]          vsp;
		logic [7:0]                 vsl;
		logic [7:0]                 lex;
		logic [7:0]                 ul;
		logic [63:0]                sv;
		logic [SBC_NS_W-1:0]        pend;
		logic [SBC_NS_W-1:0]        pop;
		logic [63:0]                rdat;
		logic [SBC_HWS_W-1:0]       hws;
		logic [SBC_CHL_W-1:0]       chl;
		logic [2:0][63:0]           pst;
		sbc_mreq_t                  m;
	} sbc_st_t;

	sbc_st_t    s_q;
	sbc_st_t    s_d;
	logic       acc;
	logic [3:0] rh;
	logic [3:0] dh;

	function automatic sbc_st_t gm(sbc_st_t s, logic we, logic [SBC_AW-1:0] a, logic [255:0] w,
		sbc_mop_t o, sbc_fsm_t r);
		s.m.req = 1'b1;
		s.m.we = we;
		s.m.addr = a;
		s.m.wdata = w;
		s.mop = o;
		s.ret = r;
		s.st = ST_MEM;
		return s;
	endfunction : gm

	function automatic sbc_st_t dins(sbc_st_t s, logic [7:0] t, logic [63:0] d);
		logic [3:0] h;
		logic [3:0] e;
		logic [2:0] k;
		h = sbc_hit(s.dtag, s.dval, t);
		e = sbc_free(s.dval);
		k = h[3] ? h[2:0] : (e[3] ? e[2:0] : s.dp);
		if (!h[3] && !e[3])
			s.dp = s.dp + 3'h1;
		s.ddat[k] = d;
		s.dtag[k] = t;
		s.dval[k] = 1'b1;
		return s;
	endfunction : dins

	assign acc = s_q.rdy && req_i.op != C_NOP;
	assign rh = sbc_hit(s_q.rtag, s_q.rval, req_i.seg);
	assign dh = sbc_hit(s_q.dtag, s_q.dval, s_q.key);

	always_comb begin
		logic [3:0] e;
		sbc_scw_t   c;
		logic [7:0] nl;
		e = 4'h0;
		c = sbc_scw_t'(s_q.pop[SBC_SCW_W-1:0]);
		nl = 8'h00;
		s_d = s_q;
		s_d.flt = 1'b0;
		s_d.rv = 1'b0;
		s_d.dvl = 1'b0;
		s_d.pv = 1'b0;
		s_d.pld = 1'b0;
		case (s_q.st)
			ST_IDLE: begin
				if (acc) begin
					s_d.rq = req_i;
					s_d.nxt = ST_IDLE;
					case (req_i.op)
						C_PCALL: begin
							s_d.idx = 2'h0;
							s_d.rval = 8'h00;
							s_d = gm(s_d, 1'b0, rs_base_i, '0, M_PCALL, ST_IDLE);
						end
						C_RES_RD: begin
							if (req_i.seg < SBC_SEG_MIN)
								s_d.flt = 1'b1;
							else if (rh[3]) begin
								s_d.rdat = s_q.rdat_a[rh[2:0]];
								s_d.rv = 1'b1;
							end else
								s_d = gm(s_d, 1'b0, rs_base_i + SBC_AW'(req_i.seg), '0, M_RES, ST_IDLE);
						end
						C_DISP_RD: begin
							s_d.key = req_i.lvl;
							s_d.st = ST_DRD;
						end
						C_NS_PUSH: begin
							s_d.pend = req_i.nsd;
							s_d.st = ST_PUSH;
						end
						C_NS_POP:
							s_d.st = ST_POP;
						C_SLICE: begin
							s_d.key = s_q.lex;
							s_d.st = ST_SLICE;
						end
						C_EXEC:
							s_d = gm(s_d, 1'b0, ns_base_i + req_i.link, '0, M_SCW, ST_EXEC);
						C_UNSLICE, C_PRET: begin
							s_d.nxt = ST_UNSL;
							s_d.st = ST_POP;
						end
						default: s_d.st = ST_IDLE;
					endcase
				end
			end
			ST_MEM: begin
				if (mem_ack_i) begin
					s_d.m.req = 1'b0;
					s_d.st = s_q.ret;
					case (s_q.mop)
						M_PCALL: begin
							if (s_q.idx == 2'h0) begin
								s_d.rdat_a[0] = mem_rdata_i[63:0];
								s_d.rtag[0] = 8'h00;
								s_d.rval[0] = 1'b1;
								s_d.rp = 3'h1;
								s_d.hws = mem_rdata_i[SBC_HWS_LSB +: SBC_HWS_W];
								s_d.chl = mem_rdata_i[SBC_CHL_LSB +: SBC_CHL_W];
							end else
								s_d.pst[s_q.idx - 2'h1] = mem_rdata_i[63:0];
							if (s_q.idx == 2'(SBC_PST_N)) begin
								s_d.pld = 1'b1;
								s_d.st = ST_IDLE;
							end else begin
								s_d.idx = s_q.idx + 2'h1;
								s_d = gm(s_d, 1'b0, rs_base_i + SBC_AW'(s_q.idx + 2'h1), '0, M_PCALL, ST_IDLE);
							end
						end
						M_RES: begin
							e = sbc_free(s_q.rval | 8'h01);
							if (!e[3]) begin
								e[2:0] = s_q.rp;
								s_d.rp = (s_q.rp == 3'h7) ? 3'h1 : s_q.rp + 3'h1;
							end
							s_d.rdat_a[e[2:0]] = mem_rdata_i[63:0];
							s_d.rtag[e[2:0]] = s_q.rq.seg;
							s_d.rval[e[2:0]] = 1'b1;
							s_d.rdat = mem_rdata_i[63:0];
							s_d.rv = 1'b1;
						end
						M_NSPL: begin
							s_d.nsc = s_q.nsc - 3'h1;
							s_d.nsp = s_q.nsp + SBC_AW'(1);
						end
						M_VSPL: begin
							s_d.vsc = s_q.vsc - 3'h1;
							s_d.vsp = s_q.vsp + SBC_AW'(1);
						end
						M_NFIL: begin
							s_d.ns[0] = mem_rdata_i[SBC_NS_W-1:0];
							s_d.nsc = 3'h1;
							s_d.nsp = s_q.nsp - SBC_AW'(1);
						end
						M_VFIL: begin
							s_d.vs[0] = mem_rdata_i;
							s_d.vsc = 3'h1;
							s_d.vsp = s_q.vsp - SBC_AW'(1);
						end
						M_DSP:
							s_d = dins(s_d, s_q.key, mem_rdata_i[63:0]);
						default:
							s_d.pop = mem_rdata_i[SBC_NS_W-1:0];
					endcase
				end
			end
			ST_DRD: begin
				if (dh[3]) begin
					s_d.rdat = s_q.ddat[dh[2:0]];
					s_d.dvl = 1'b1;
					s_d.st = ST_IDLE;
				end else
					s_d = gm(s_d, 1'b0, ds_base_i + SBC_AW'(s_q.key), '0, M_DSP, ST_DRD);
			end
			ST_SLICE: begin
				if (dh[3]) begin
					c.disp = s_q.ddat[dh[2:0]];
					c.lex = s_q.lex + 8'h01;
					c.len = s_q.rq.len;
					s_d.pend = SBC_NS_W'(c);
					s_d = dins(s_d, c.lex, s_q.rq.desc);
					s_d.lex = c.lex;
					s_d.vsl = s_q.vsl + 8'h01;
					s_d.st = ST_PUSH;
				end else
					s_d = gm(s_d, 1'b0, ds_base_i + SBC_AW'(s_q.key), '0, M_DSP, ST_SLICE);
			end
			ST_EXEC: begin
				nl = c.lex + 8'h01;
				s_d.sv = c.disp;
				c.lex = nl;
				c.len = s_q.rq.len;
				s_d.pend = SBC_NS_W'(c);
				s_d = dins(s_d, nl, s_q.rq.desc);
				s_d.lex = nl;
				s_d.ul = nl - 8'h01;
				s_d.key = nl - 8'h01;
				s_d.vsl = s_q.vsl + 8'h01;
				s_d.nxt = ST_UPD;
				s_d.st = ST_PUSH;
			end
			ST_UPD: begin
				if (!dh[3])
					s_d = gm(s_d, 1'b0, ds_base_i + SBC_AW'(s_q.key), '0, M_DSP, ST_UPD);
				else if (s_q.ddat[dh[2:0]] == s_q.sv)
					s_d.st = ST_IDLE;
				else begin
					s_d = dins(s_d, s_q.ul, s_q.sv);
					if (s_q.ul == 8'h00)
						s_d.st = ST_IDLE;
					else
						s_d = gm(s_d, 1'b0, s_q.sv[SBC_AW-1:0], '0, M_SCW, ST_UPDN);
				end
			end
			ST_UPDN: begin
				s_d.sv = c.disp;
				s_d.ul = s_q.ul - 8'h01;
				s_d.key = s_q.ul - 8'h01;
				s_d.st = ST_UPD;
			end
			ST_UNSL: begin
				for (int i = 0; i < SBC_DSP_N; i++) begin
					if (s_q.dtag[i] == s_q.lex)
						s_d.dval[i] = 1'b0;
				end
				s_d.lex = s_q.lex - 8'h01;
				s_d.vsl = s_q.vsl - 8'h01;
				s_d.sv = c.disp;
				s_d.ul = s_q.lex - 8'h02;
				s_d.key = s_q.lex - 8'h02;
				s_d.st = (s_q.rq.op == C_PRET && s_q.lex > 8'h01) ? ST_UPD : ST_IDLE;
			end
			ST_PUSH: begin
				if (s_q.nsc == SBC_NS_FULL)
					s_d = gm(s_d, 1'b1, ns_base_i + s_q.nsp, SBC_MD_W'(s_q.ns[3]), M_NSPL, ST_PUSH);
				else if (s_q.pend[SBC_VREF] && s_q.vsc == SBC_NS_FULL)
					s_d = gm(s_d, 1'b1, vs_base_i + s_q.vsp, s_q.vs[3], M_VSPL, ST_PUSH);
				else begin
					s_d.ns = {s_q.ns[2:0], s_q.pend};
					s_d.nsc = s_q.nsc + 3'h1;
					if (s_q.pend[SBC_VREF]) begin
						s_d.vs = {s_q.vs[2:0], s_q.rq.vsd};
						s_d.vsc = s_q.vsc + 3'h1;
					end
					s_d.st = s_q.nxt;
				end
			end
			ST_POP: begin
				if (s_q.nsc == 3'h0) begin
					if (s_q.nsp == '0) begin
						s_d.flt = 1'b1;
						s_d.st = ST_IDLE;
					end else
						s_d = gm(s_d, 1'b0, ns_base_i + s_q.nsp - SBC_AW'(1), '0, M_NFIL, ST_POP);
				end else if (s_q.ns[0][SBC_VREF] && s_q.vsc == 3'h0 && s_q.vsp != '0)
					s_d = gm(s_d, 1'b0, vs_base_i + s_q.vsp - SBC_AW'(1), '0, M_VFIL, ST_POP);
				else begin
					s_d.pop = s_q.ns[0];
					s_d.ns = {SBC_NS_W'(0), s_q.ns[3:1]};
					s_d.nsc = s_q.nsc - 3'h1;
					if (s_q.ns[0][SBC_VREF] && s_q.vsc != 3'h0) begin
						s_d.vs = {SBC_VS_W'(0), s_q.vs[3:1]};
						s_d.vsc = s_q.vsc - 3'h1;
					end
					s_d.pv = 1'b1;
					s_d.st = s_q.nxt;
				end
			end
			default: s_d.st = ST_IDLE;
		endcase
		s_d.vref = s_d.nsc != 3'h0 && s_d.ns[0][SBC_VREF];
		s_d.rdy = s_d.st == ST_IDLE;
	end

	always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			s_q <= '0;
			s_q.st <= ST_IDLE;
			s_q.ret <= ST_IDLE;
			s_q.nxt <= ST_IDLE;
			s_q.rdy <= 1'b1;
			s_q.rp <= 3'h1;
		end else
			s_q <= s_d;
	end

	assign rdy_o = s_q.rdy;
	assign fault_o = s_q.flt;
	assign rvld_o = s_q.rv;
	assign dvld_o = s_q.dvl;
	assign rdat_o = s_q.rdat;
	assign pvld_o = s_q.pv;
	assign pop_o = s_q.pop;
	assign vref_o = s_q.vref;
	assign vtop_o = s_q.vs[0];
	assign lex_o = s_q.lex;
	assign vsl_o = s_q.vsl;
	assign hws_o = s_q.hws;
	assign chalt_o = s_q.chl;
	assign pst_o = s_q.pst;
	assign pld_o = s_q.pld;
	assign mem_o = s_q.m;

	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (!reset_n_i);

	a_seg_fault: assert property (acc && req_i.op == C_RES_RD && req_i.seg < SBC_SEG_MIN
		|=> fault_o && !mem_o.req && rdy_o) else $error("low segment not faulted");
	a_hit_local: assert property (acc && req_i.op == C_RES_RD && req_i.seg >= SBC_SEG_MIN && rh[3]
		|=> rvld_o && !mem_o.req && rdat_o == $past(s_q.rdat_a[rh[2:0]])) else $error("hit went to memory");
	a_miss_fetch: assert property (acc && req_i.op == C_RES_RD && req_i.seg >= SBC_SEG_MIN && !rh[3]
		|=> mem_o.req && !mem_o.we && mem_o.addr == $past(rs_base_i) + SBC_AW'($past(req_i.seg)))
		else $error("miss fetch address wrong");
	a_env_kept: assert property (s_q.rval[0] && !(acc && req_i.op == C_PCALL)
		|=> s_q.rval[0] && s_q.rtag[0] == 8'h00) else $error("environment slot lost");
	a_pcall_empty: assert property (acc && req_i.op == C_PCALL
		|=> s_q.rval == 8'h00 ##1 !rdy_o) else $error("slots not emptied at process call");
	a_state_load: assert property (pld_o |-> rdy_o && s_q.rval == 8'h01 && s_q.idx == 2'(SBC_PST_N) && $past(mem_ack_i))
		else $error("state load out of order");
	a_miss_stall: assert property (mem_o.req && !mem_ack_i |=> !rdy_o && mem_o.req)
		else $error("request taken during fetch");
	a_ns_depth: assert property (s_q.nsc <= SBC_NS_FULL && s_q.vsc <= SBC_NS_FULL)
		else $error("stack buffer overfilled");
	a_push_top: assert property (acc && req_i.op == C_NS_PUSH && s_q.nsc < SBC_NS_FULL
		&& !(req_i.nsd[SBC_VREF] && s_q.vsc == SBC_NS_FULL) |=> ##1 s_q.ns[0] == $past(req_i.nsd, 2) && rdy_o)
		else $error("push did not land on top");
	a_vref_flag: assert property (vref_o |-> s_q.nsc != 3'h0 && s_q.ns[0][SBC_VREF])
		else $error("value reference flag wrong");
endmodule : sbc_top

/* tb/sbc_tb_pkg.sv */
package sbc_tb_pkg;
	// content of untouched level-1 words, a function of the address only
	function automatic logic [255:0] sbc_pat(logic [31:0] a);
		return {4{~a, a ^ 32'h3C5A_9E00}};
	endfunction : sbc_pat
endpackage : sbc_tb_pkg

/* tb/sbc_mem_model.sv */
`timescale 1ns/10ps
module sbc_mem_model
	import sbc_pkg::*;
	import sbc_tb_pkg::*;
(
	input  wire logic                         clk_i,     // clock
	input  wire logic                         reset_n_i, // async reset
	input  wire sbc_pkg::sbc_mreq_t           mem_i,     // request from the block
	input  wire logic                         slow_i,    // insert random wait states
	output logic                              ack_o,     // completion pulse
	output logic [sbc_pkg::SBC_MD_W-1:0]      rdata_o    // read data, valid with ack
);
	logic [255:0] store [logic [31:0]];
	logic [1:0]   dly_q;

	// data lines invert every cycle outside an ack, so the last word shows again every other cycle
	always @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			ack_o   <= 1'b0;
			rdata_o <= '1;
			dly_q   <= 2'h0;
		end else if (ack_o) begin
			ack_o   <= 1'b0;
			rdata_o <= ~rdata_o;
			dly_q   <= slow_i ? 2'($urandom_range(3)) : 2'h0;
		end else if (mem_i.req && dly_q != 2'h0) begin
			dly_q   <= dly_q - 2'h1;
			rdata_o <= ~rdata_o;
		end else if (mem_i.req) begin
			ack_o <= 1'b1;
			if (mem_i.we)
				store[mem_i.addr] = mem_i.wdata;
			rdata_o <= mem_i.we ? ~rdata_o : (store.exists(mem_i.addr) ? store[mem_i.addr] : sbc_pat(mem_i.addr));
		end else begin
			rdata_o <= ~rdata_o;
		end
	end
endmodule : sbc_mem_model

/* tb/sbc_top_test.sv */
`timescale 1ns/10ps
module sbc_top_test;
	import sbc_pkg::*;
	import sbc_tb_pkg::*;

	logic                  ref_clk = 1'b0;
	logic                  reset_n;
	sbc_req_t              req;
	logic                  rdy, fault, rvld, dvld, pvld, vref, pld, ack, slow;
	logic [SBC_RE_W-1:0]   rdat;
	logic [SBC_NS_W-1:0]   pop;
	logic [SBC_VS_W-1:0]   vtop;
	logic [7:0]            lex, vsl;
	logic [SBC_HWS_W-1:0]  hws;
	logic [SBC_CHL_W-1:0]  chalt;
	logic [2:0][63:0]      pst;
	logic [SBC_AW-1:0]     rs, ds, ns, vs, watch, last_a;
	sbc_mreq_t             mem;
	logic [SBC_MD_W-1:0]   rdata;
	logic [255:0]          e, w, w2;
	logic [63:0]           got_d, disp0;
	logic [127:0]          got_p;
	logic [127:0]          q [$];
	logic [7:0]            s0, ll0, v0;
	logic                  f_seen, p_seen, l_seen, ex_seen;
	int                    error_cnt, num_checks, nrd, nwr, nrd0, nwr0, lat;

	always #4 ref_clk = ~ref_clk;

	sbc_top dut_u (
		.ref_clk_i(ref_clk), .reset_n_i(reset_n), .req_i(req), .rdy_o(rdy), .fault_o(fault),
		.rvld_o(rvld), .dvld_o(dvld), .rdat_o(rdat), .pvld_o(pvld), .pop_o(pop), .vref_o(vref),
		.vtop_o(vtop), .lex_o(lex), .vsl_o(vsl), .hws_o(hws), .chalt_o(chalt), .pst_o(pst),
		.pld_o(pld), .rs_base_i(rs), .ds_base_i(ds), .ns_base_i(ns), .vs_base_i(vs),
		.mem_o(mem), .mem_ack_i(ack), .mem_rdata_i(rdata)
	);

	sbc_mem_model mem_u (
		.clk_i(ref_clk), .reset_n_i(reset_n), .mem_i(mem), .slow_i(slow), .ack_o(ack), .rdata_o(rdata)
	);

	// level-1 traffic seen at the ports
	always @(posedge ref_clk) begin
		if (mem.req === 1'b1 && ack === 1'b1) begin
			if (mem.we === 1'b1)
				nwr++;
			else begin
				nrd++;
				last_a = mem.addr;
				if (mem.addr === watch)
					ex_seen = 1'b1;
			end
		end
	end

	task automatic report_and_stop();
		if (error_cnt == 0 && num_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : report_and_stop

	task automatic chk(input logic [255:0] s, input logic [255:0] x);
		num_checks++;
		if (s !== x) begin
			error_cnt++;
			$display("mismatch t=%0t seen=%h exp=%h", $time, s, x);
		end
	endtask : chk

	// one request, called at a falling edge; collects the answer until idle
	task automatic go(input sbc_cmd_t op, input logic [7:0] sv, input logic [255:0] wv);
		int n;
		n = 0;
		while (rdy !== 1'b1) begin
			n++;
			if (n > 5000) begin
				error_cnt++;
				report_and_stop();
			end
			@(negedge ref_clk);
		end
		slow = 1'($urandom);
		req.op = op;
		req.seg = sv;
		req.lvl = sv;
		req.nsd = wv[127:0];
		req.vsd = wv;
		req.desc = wv[63:0];
		req.len = wv[27:0];
		req.link = wv[31:0];
		@(negedge ref_clk);
		req.op = C_NOP;
		{f_seen, p_seen, l_seen} = 3'h0;
		lat = 0;
		nrd0 = nrd;
		nwr0 = nwr;
		// first look is the cycle right after the taking edge
		for (n = 1; n <= 5000; n++) begin
			if (rvld === 1'b1 || dvld === 1'b1 || fault === 1'b1)
				lat = n;
			if (rvld === 1'b1 || dvld === 1'b1)
				got_d = rdat;
			f_seen |= (fault === 1'b1);
			l_seen |= (pld === 1'b1);
			if (pvld === 1'b1) begin
				p_seen = 1'b1;
				got_p = pop;
			end
			if (rdy === 1'b1 && n >= 2)
				break;
			@(negedge ref_clk);
		end
		if (n > 5000) begin
			error_cnt++;
			report_and_stop();
		end
	endtask : go

	task automatic rd(input logic [7:0] s, input int miss);
		go(C_RES_RD, s, '0);
		e = sbc_pat(rs + 32'(s));
		chk(got_d, e[63:0]);
		chk(nrd - nrd0, miss);
		if (miss != 0)
			chk(last_a, rs + 32'(s));
		else
			chk(lat, 1);
	endtask : rd

	initial begin
		void'($urandom(42604));
		req = '0;
		slow = 1'b0;
		reset_n = 1'b0;
		watch = '1;
		ex_seen = 1'b0;
		rs = 32'h0001_0000 + ($urandom & 32'h0000_0FF0);
		ds = 32'h0002_0000 + ($urandom & 32'h0000_0FF0);
		ns = 32'h0003_0000 + ($urandom & 32'h0000_0FF0);
		vs = 32'h0004_0000 + ($urandom & 32'h0000_0FF0);
		repeat (16) @(negedge ref_clk);
		reset_n = 1'b1;
		chk(rdy, 1'b1);
		chk(mem.req, 1'b0);
		@(negedge ref_clk);
		go(C_PCALL, 8'h00, '0);
		e = sbc_pat(rs);
		chk(hws, e[15:0]);
		chk(chalt, e[31:16]);
		chk(l_seen, 1'b1);
		for (int i = 0; i < 3; i++) begin
			e = sbc_pat(rs + 32'(i + 1));
			chk(pst[i], e[63:0]);
		end
		for (int s = 0; s < 4; s++) begin
			go(C_RES_RD, 8'(s), '0);
			chk({f_seen, 8'(lat), 8'(nrd - nrd0)}, {1'b1, 8'h01, 8'h00});
		end
		s0 = 8'(4 + $urandom_range(200));
		for (int i = 0; i < 7; i++)
			rd(s0 + 8'(i), 1);
		rd(s0 + 8'h01, 0);
		rd(s0 + 8'h07, 1);
		rd(s0 + 8'h01, 0);
		rd(s0, 1);
		go(C_PCALL, 8'h00, '0);
		rd(s0 + 8'h03, 1);
		for (int i = 0; i < 6; i++) begin
			for (int j = 0; j < 8; j++)
				w[j * 32 +: 32] = $urandom;
			w[127] = i[0];
			go(C_NS_PUSH, 8'h00, w);
			chk(vref, w[127]);
			if (w[127])
				chk(vtop, w);
			if (i < 4)
				chk(nwr - nwr0, 0);
			q.push_back(w[127:0]);
		end
		for (int i = 0; i < 6; i++) begin
			go(C_NS_POP, 8'h00, '0);
			chk(got_p, q.pop_back());
		end
		go(C_NS_POP, 8'h00, '0);
		chk(f_seen, 1'b1);
		ll0 = lex;
		v0 = vsl;
		go(C_DISP_RD, ll0, '0);
		e = sbc_pat(ds + 32'(ll0));
		disp0 = got_d;
		chk(got_d, e[63:0]);
		for (int j = 0; j < 8; j++)
			w[j * 32 +: 32] = $urandom;
		go(C_SLICE, ll0 + 8'h01, w);
		chk(lex, 8'(ll0 + 8'h01));
		chk(vsl, v0 + 8'h01);
		go(C_DISP_RD, ll0 + 8'h01, '0);
		chk(got_d, w[63:0]);
		chk(nrd - nrd0, 0);
		go(C_UNSLICE, 8'h00, '0);
		chk(got_p[27:0], w[27:0]);
		chk(got_p[99:36], disp0);
		chk(lex, ll0);
		chk(vsl, v0);
		w2 = {224'h0, 8'(16 + $urandom_range(60)), 24'($urandom) & 24'h00_0000};
		w2[27:0] = 28'h000_0000 | (28'($urandom) & 28'hFFF_FF00) | 28'(w2[31:24]);
		watch = ns + 32'(w2[31:0]);
		go(C_EXEC, 8'h00, w2);
		e = sbc_pat(watch);
		chk(ex_seen, 1'b1);
		chk(lex, 8'(e[35:28] + 8'h01));
		go(C_PRET, 8'h00, '0);
		chk(p_seen, 1'b1);
		chk(got_p[27:0], w2[27:0]);
		report_and_stop();
	end
endmodule : sbc_top_test
